// ---- core/frtic_pkg.sv ----
// constants and types for the flash reset, terminate and id command logic
package frtic_pkg;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_TERMINATE = 8'hF0;
  localparam logic [7:0] TERM_CONFIRM = 8'hD0;
  localparam logic [7:0] OP_ID_SINGLE = 8'h90;
  localparam logic [7:0] OP_ID_QUAD = 8'h94;
  // single id read: opcode bits then 24 dummy clocks
  localparam int ID1_DUMMY_CLKS = 24;
  // quad id read: 6 address clocks, 2 mode clocks, 4 dummy clocks
  localparam int ID4_ADDR_CLKS = 6;
  localparam int ID4_MODE_CLKS = 2;
  localparam int ID4_DUMMY_CLKS = 4;
  localparam int ID4_SKIP_CLKS = ID4_ADDR_CLKS + ID4_MODE_CLKS + ID4_DUMMY_CLKS;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_START_DELAY_NS = 1000;
  localparam int TERMINATE_START_DELAY_NS = 1000;
  // longest times round down, at least one cycle
  localparam int RESET_START_CYC = (RESET_START_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (RESET_START_DELAY_NS / CLK_PERIOD_NS);
  localparam int TERM_START_CYC = (TERMINATE_START_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (TERMINATE_START_DELAY_NS / CLK_PERIOD_NS);
  localparam int BUSY_CYC = 8;
  localparam int CNT_W = 6;
  localparam logic [7:0] MFR_ID_DEFAULT = 8'hA5;
  localparam logic [7:0] DEV_ID_DEFAULT = 8'h3C;
  typedef enum logic [2:0] {
    FRTIC_ST_OPCODE,
    FRTIC_ST_CONFIRM,
    FRTIC_ST_ID1,
    FRTIC_ST_ID4,
    FRTIC_ST_IGNORE
  } frtic_phase_t;
  typedef enum logic [1:0] {
    FRTIC_RUN_IDLE,
    FRTIC_RUN_RESET,
    FRTIC_RUN_TERM
  } frtic_run_t;
endpackage

// ---- core/frtic_sync.sv ----
// two-flop synchroniser with edge detection on the synchronised copy
`timescale 1ns/1ns
module frtic_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // raw and synchronised levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] last;
  } frtic_sync_st_t;
  frtic_sync_st_t st_ff;
  frtic_sync_st_t nxt_st;
  always_comb
  begin
    nxt_st.meta = i_async;
    nxt_st.sync = st_ff.meta;
    nxt_st.last = st_ff.sync;
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      st_ff.meta <= '0;
      st_ff.sync <= '0;
      st_ff.last <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
  assign o_sync = st_ff.sync;
  assign o_rise = st_ff.sync & ~st_ff.last;
  assign o_fall = ~st_ff.sync & st_ff.last;
endmodule

// ---- core/frtic_core.sv ----
// serial flash command logic: software reset, terminate and id reads
// Operation
// - reset-enable then reset opcodes decoded msb first
// - reset counts only directly after reset-enable
// - reset starts within delay, commands rejected
// - reset-enable off byte boundary is discarded
// - terminate keeps volatile configuration intact
// - terminate aborts program or erase, ignoring latch
// - terminate ignored unless terminate_enable set
// - wrong confirmation byte ignores whole command
// - terminate starts within delay, commands rejected
// - aborted page contents become undefined
// - terminate off byte boundary returns to standby
// - single id: 24 dummy clocks, 16 data clocks
// - id repeats while selected, released on deselect
// - quad id: 6 address, 2 mode, 4 dummy
// - quad nibble order io3 io2 so si
// - quad id alternates bytes two clocks each
// - reset reinitialises all state to defaults
// - reset opcodes are command-only frames
`timescale 1ns/1ns
module frtic_core #(
  parameter logic [7:0] MFR_ID = frtic_pkg::MFR_ID_DEFAULT, // arbitrary value
  parameter logic [7:0] DEV_ID = frtic_pkg::DEV_ID_DEFAULT, // arbitrary value
  parameter int RESET_CYC = frtic_pkg::RESET_START_CYC,
  parameter int TERM_CYC = frtic_pkg::TERM_START_CYC,
  parameter int BUSY_LEN = frtic_pkg::BUSY_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // spi link pins from the host
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_si,
  // two-way data lines: 0 si, 1 so, 2 protect_io2, 3 pause_io3
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  // internal device state
  input wire logic i_busy_flag,
  input wire logic i_suspended_flag,
  input wire logic i_write_enable_latch,
  input wire logic i_terminate_enable,
  // effects on the program/erase engine and registers
  output logic o_pe_abort,
  output logic o_page_undefined,
  output logic o_soft_reset,
  output logic o_cmd_busy,
  output logic o_reset_armed
);
  typedef struct packed {
    frtic_pkg::frtic_phase_t phase;
    frtic_pkg::frtic_run_t run;
    logic [7:0] shreg;
    logic [frtic_pkg::CNT_W-1:0] bitcnt;
    logic [frtic_pkg::CNT_W-1:0] skip;
    logic [15:0] delay;
    logic armed;
    logic term_ok;
    logic [7:0] pend_op;
    logic [3:0] io;
    logic [3:0] io_oe;
    logic [3:0] outpos;
    logic pe_abort;
    logic page_undef;
    logic soft_reset;
    logic busy;
  } frtic_st_t;

  frtic_st_t st_ff;
  frtic_st_t nxt_st;
  logic cs_n_s;
  logic [3:0] io_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  logic [5:0] sy_val;
  logic [5:0] sy_rise;
  logic [5:0] sy_fall;

  // all pins pass two flops before any decode
  frtic_sync #(.W(6)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_cs_n, i_sclk, i_io[3:1], i_si}),
    .o_sync(sy_val),
    .o_rise(sy_rise),
    .o_fall(sy_fall)
  );
  assign cs_n_s = sy_val[5];
  assign io_s = sy_val[3:0];
  assign sclk_rise = sy_rise[4] & ~cs_n_s;
  assign sclk_fall = sy_fall[4] & ~cs_n_s;
  assign cs_rise = sy_rise[5];
  assign cs_fall = sy_fall[5];

  // id bit pattern for a position in the 16-bit mfr/dev pair
  function automatic logic id_bit(input logic [3:0] pos);
    logic [15:0] pair;
    pair = {MFR_ID, DEV_ID};
    id_bit = pair[4'hF - pos];
  endfunction

  always_comb
  begin
    logic [7:0] byte_now;
    nxt_st = st_ff;
    byte_now = {st_ff.shreg[6:0], io_s[0]};
    nxt_st.pe_abort = 1'b0;
    nxt_st.soft_reset = 1'b0;
    // internal operation countdown; new commands rejected meanwhile
    if (st_ff.run != frtic_pkg::FRTIC_RUN_IDLE)
    begin
      nxt_st.delay = st_ff.delay - 16'h0001;
      if (st_ff.delay == 16'(BUSY_LEN))
      begin
        if (st_ff.run == frtic_pkg::FRTIC_RUN_RESET)
        begin
          nxt_st.soft_reset = 1'b1;
          nxt_st.pe_abort = 1'b1;
          nxt_st.page_undef = 1'b0;
          nxt_st.armed = 1'b0;
        end
        else
        begin
          // abort regardless of write_enable_latch; config untouched
          nxt_st.pe_abort = 1'b1;
          nxt_st.page_undef = i_busy_flag;
        end
      end
      if (st_ff.delay == 16'h0000)
      begin
        nxt_st.run = frtic_pkg::FRTIC_RUN_IDLE;
      end
    end
    if (cs_fall)
    begin
      nxt_st.bitcnt = '0;
      nxt_st.shreg = '0;
      nxt_st.skip = '0;
      nxt_st.outpos = '0;
      nxt_st.phase = (st_ff.run == frtic_pkg::FRTIC_RUN_IDLE) ? frtic_pkg::FRTIC_ST_OPCODE
        : frtic_pkg::FRTIC_ST_IGNORE;
      nxt_st.pend_op = '0;
    end
    else if (sclk_rise)
    begin
      case (st_ff.phase)
        frtic_pkg::FRTIC_ST_OPCODE:
        begin
          nxt_st.shreg = byte_now;
          nxt_st.bitcnt = st_ff.bitcnt + 1'b1;
          if (st_ff.bitcnt == 6'd7)
          begin
            nxt_st.bitcnt = '0;
            nxt_st.pend_op = byte_now;
            // any other opcode clears the reset-enable state
            if (byte_now != frtic_pkg::OP_RESET && byte_now != frtic_pkg::OP_RESET_ENABLE)
            begin
              nxt_st.armed = 1'b0;
            end
            case (byte_now)
              frtic_pkg::OP_TERMINATE:
              begin
                nxt_st.phase = i_terminate_enable ? frtic_pkg::FRTIC_ST_CONFIRM
                  : frtic_pkg::FRTIC_ST_IGNORE;
              end
              frtic_pkg::OP_ID_SINGLE:
              begin
                nxt_st.phase = frtic_pkg::FRTIC_ST_ID1;
              end
              frtic_pkg::OP_ID_QUAD:
              begin
                nxt_st.phase = frtic_pkg::FRTIC_ST_ID4;
              end
              default:
              begin
                nxt_st.phase = frtic_pkg::FRTIC_ST_IGNORE;
              end
            endcase
          end
        end
        frtic_pkg::FRTIC_ST_CONFIRM:
        begin
          nxt_st.shreg = byte_now;
          nxt_st.bitcnt = st_ff.bitcnt + 1'b1;
          if (st_ff.bitcnt == 6'd7)
          begin
            nxt_st.bitcnt = '0;
            nxt_st.term_ok = (byte_now == frtic_pkg::TERM_CONFIRM);
            nxt_st.phase = frtic_pkg::FRTIC_ST_IGNORE;
          end
        end
        frtic_pkg::FRTIC_ST_ID1:
        begin
          if (st_ff.skip != 6'(frtic_pkg::ID1_DUMMY_CLKS))
          begin
            nxt_st.skip = st_ff.skip + 1'b1;
          end
        end
        frtic_pkg::FRTIC_ST_ID4:
        begin
          if (st_ff.skip != 6'(frtic_pkg::ID4_SKIP_CLKS))
          begin
            nxt_st.skip = st_ff.skip + 1'b1;
          end
        end
        frtic_pkg::FRTIC_ST_IGNORE:
        begin
          nxt_st.bitcnt = (st_ff.bitcnt == 6'd7) ? '0 : st_ff.bitcnt + 1'b1;
        end
        default:
        begin
          nxt_st.phase = frtic_pkg::FRTIC_ST_IGNORE;
        end
      endcase
      // any extra byte makes a reset frame no longer command-only
      if (st_ff.phase == frtic_pkg::FRTIC_ST_IGNORE && st_ff.bitcnt == 6'd7)
      begin
        nxt_st.pend_op = '0;
        if (st_ff.pend_op == frtic_pkg::OP_TERMINATE)
        begin
          nxt_st.term_ok = 1'b0;
        end
      end
    end
    else if (sclk_fall)
    begin
      // data launched on the falling edge so the host samples on rising
      if (st_ff.phase == frtic_pkg::FRTIC_ST_ID1
        && st_ff.skip == 6'(frtic_pkg::ID1_DUMMY_CLKS))
      begin
        nxt_st.io_oe = 4'h2;
        nxt_st.io = {2'h0, id_bit(st_ff.outpos), 1'b0};
        nxt_st.outpos = st_ff.outpos + 4'h1;
      end
      else if (st_ff.phase == frtic_pkg::FRTIC_ST_ID4
        && st_ff.skip == 6'(frtic_pkg::ID4_SKIP_CLKS))
      begin
        nxt_st.io_oe = 4'hF;
        nxt_st.io = {id_bit(st_ff.outpos), id_bit(st_ff.outpos + 4'h1),
          id_bit(st_ff.outpos + 4'h2), id_bit(st_ff.outpos + 4'h3)};
        nxt_st.outpos = st_ff.outpos + 4'h4;
      end
    end
    if (cs_rise)
    begin
      nxt_st.io_oe = 4'h0;
      nxt_st.io = 4'h0;
      nxt_st.phase = frtic_pkg::FRTIC_ST_IGNORE;
      // off a byte boundary nothing is acted upon
      if (st_ff.bitcnt == 6'd0 && st_ff.run == frtic_pkg::FRTIC_RUN_IDLE)
      begin
        if (st_ff.pend_op == frtic_pkg::OP_RESET_ENABLE)
        begin
          nxt_st.armed = 1'b1;
        end
        else if (st_ff.pend_op == frtic_pkg::OP_RESET)
        begin
          nxt_st.armed = 1'b0;
          if (st_ff.armed)
          begin
            nxt_st.run = frtic_pkg::FRTIC_RUN_RESET;
            nxt_st.delay = 16'(RESET_CYC + BUSY_LEN);
          end
        end
        else if (st_ff.pend_op == frtic_pkg::OP_TERMINATE && st_ff.term_ok)
        begin
          nxt_st.run = frtic_pkg::FRTIC_RUN_TERM;
          nxt_st.delay = 16'(TERM_CYC + BUSY_LEN);
        end
        else if (st_ff.pend_op != 8'h00)
        begin
          nxt_st.armed = 1'b0;
        end
      end
      else if (st_ff.pend_op == frtic_pkg::OP_RESET_ENABLE)
      begin
        nxt_st.armed = 1'b0;
      end
      nxt_st.term_ok = 1'b0;
      nxt_st.pend_op = '0;
    end
    nxt_st.busy = (nxt_st.run != frtic_pkg::FRTIC_RUN_IDLE);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      st_ff.phase <= frtic_pkg::FRTIC_ST_IGNORE;
      st_ff.run <= frtic_pkg::FRTIC_RUN_IDLE;
      st_ff.shreg <= '0;
      st_ff.bitcnt <= '0;
      st_ff.skip <= '0;
      st_ff.delay <= '0;
      st_ff.armed <= 1'b0;
      st_ff.term_ok <= 1'b0;
      st_ff.pend_op <= '0;
      st_ff.io <= '0;
      st_ff.io_oe <= '0;
      st_ff.outpos <= '0;
      st_ff.pe_abort <= 1'b0;
      st_ff.page_undef <= 1'b0;
      st_ff.soft_reset <= 1'b0;
      st_ff.busy <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_io = st_ff.io;
  assign o_io_oe = st_ff.io_oe;
  assign o_pe_abort = st_ff.pe_abort;
  assign o_page_undefined = st_ff.page_undef;
  assign o_soft_reset = st_ff.soft_reset;
  assign o_cmd_busy = st_ff.busy;
  assign o_reset_armed = st_ff.armed;
endmodule

// ---- sim/frtic_core_properties.sv ----
// concurrent checks on the reset, terminate and id command ports
`timescale 1ns/1ns
module frtic_core_properties #(
  parameter int RESET_CYC = 10,
  parameter int TERM_CYC = 10,
  parameter int BUSY_LEN = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // watched pins
  input wire logic i_cs_n,
  input wire logic [3:0] o_io_oe,
  input wire logic o_pe_abort,
  input wire logic o_page_undefined,
  input wire logic o_soft_reset,
  input wire logic o_cmd_busy,
  input wire logic o_reset_armed
);
  localparam int RC1 = RESET_CYC + 1;
  localparam int TC1 = TERM_CYC + 1;
  // busy is first seen one cycle after the rise is taken, the pulse one cycle past the count
  localparam int RC2 = RESET_CYC + 2;
  localparam int TC2 = TERM_CYC + 2;
  localparam int RSPAN = RESET_CYC + BUSY_LEN + 1;
  localparam int TSPAN = TERM_CYC + BUSY_LEN + 1;
  // length of the current busy span, too long for a repetition
  int busy_cnt_ff;
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !o_cmd_busy)
      busy_cnt_ff <= 0;
    else
      busy_cnt_ff <= busy_cnt_ff + 1;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_deselected;
    i_cs_n [*5];
  endsequence
  sequence s_term_pulse;
    o_pe_abort && !o_soft_reset;
  endsequence
  AST_RESET_START: assert property (o_soft_reset |-> $past(o_cmd_busy, RC1) && !$past(o_cmd_busy, RC2))
    else $error("soft reset off its start delay");
  AST_TERM_START: assert property (s_term_pulse |-> $past(o_cmd_busy, TC1) && !$past(o_cmd_busy, TC2))
    else $error("terminate abort off its start delay");
  AST_RESET_ABORTS: assert property (o_soft_reset |-> o_pe_abort && !o_reset_armed)
    else $error("soft reset without abort or still armed");
  AST_ABORT_PULSE: assert property (o_pe_abort |=> !o_pe_abort [*4])
    else $error("abort pulse repeated");
  AST_BUSY_SPAN: assert property ($fell(o_cmd_busy) |-> busy_cnt_ff == RSPAN || busy_cnt_ff == TSPAN)
    else $error("busy span has wrong length");
  AST_UNDEF_SET: assert property ($rose(o_page_undefined) |-> o_cmd_busy && !o_soft_reset)
    else $error("page undefined outside terminate");
  AST_UNDEF_CLEAR: assert property (o_soft_reset |=> !o_page_undefined)
    else $error("page undefined survives soft reset");
  AST_ID_RELEASE: assert property (s_deselected |-> o_io_oe == 4'h0)
    else $error("io driven while deselected");
  AST_LANES: assert property (o_io_oe != 4'h0 |-> o_io_oe == 4'h2 || o_io_oe == 4'hF)
    else $error("illegal io lane set");
endmodule
bind frtic_core frtic_core_properties #(.RESET_CYC(RESET_CYC), .TERM_CYC(TERM_CYC), .BUSY_LEN(BUSY_LEN))
  u_frtic_core_properties (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n), .o_io_oe(o_io_oe),
  .o_pe_abort(o_pe_abort), .o_page_undefined(o_page_undefined), .o_soft_reset(o_soft_reset),
  .o_cmd_busy(o_cmd_busy), .o_reset_armed(o_reset_armed));

// ---- sim/frtic_host.sv ----
// host spi controller model: mode 0 clocking, framing, io capture
`timescale 1ns/1ns
module frtic_host (
  // clock
  input wire logic i_mclk,
  // resolved io lines
  input wire logic [3:0] i_io,
  // spi pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe
);
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h0;
    o_io_oe = 4'h1;
  end
  // one 800 ns sclk period; sclk parks low between frames
  task automatic clk1(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] q);
    o_io <= d;
    o_io_oe <= oe;
    repeat (4) @(posedge i_mclk);
    o_sclk <= 1'b1;
    repeat (4) @(posedge i_mclk);
    q = i_io;
    o_sclk <= 1'b0;
  endtask
  // whole byte on the single input line, msb first
  task automatic put(input logic [7:0] b, output logic [7:0] r);
    logic [3:0] q;
    for (int i = 7; i >= 0; i--)
    begin
      clk1({3'h0, b[i]}, 4'h1, q);
      r[i] = q[1];
    end
  endtask
  // select change; deselect lasts a full sclk period
  task automatic cs(input logic v);
    o_cs_n <= v;
    repeat (8) @(posedge i_mclk);
  endtask
endmodule

// ---- sim/frtic_core_tb.sv ----
// self-checking bench for the reset, terminate and id command logic
`timescale 1ns/1ns
module frtic_core_tb;
  // arbitrary identity values
  localparam logic [7:0] MFR = 8'h5A;
  localparam logic [7:0] DEV = 8'hC3;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_busy_flag = 1'b0;
  logic i_suspended_flag = 1'b0;
  logic i_write_enable_latch = 1'b1;
  logic i_terminate_enable = 1'b0;
  logic cs_n, sclk;
  logic flip = 1'b0;
  logic [3:0] h_io, h_oe, d_io, d_oe, io_w;
  logic o_pe_abort, o_page_undefined, o_soft_reset, o_cmd_busy, o_reset_armed;
  logic [7:0] r;
  int fail_count = 0;
  int cmp_count = 0;
  int n_abort = 0;
  int n_srst = 0;
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    flip <= ~flip;
    n_abort <= n_abort + int'(o_pe_abort);
    n_srst <= n_srst + int'(o_soft_reset);
  end
  // undriven lines toggle so a stale value never reads as valid
  assign io_w = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & {4{flip}});
  frtic_core #(.MFR_ID(MFR), .DEV_ID(DEV)) u_frtic_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_si(io_w[0]), .i_io(io_w), .o_io(d_io), .o_io_oe(d_oe), .i_busy_flag(i_busy_flag),
    .i_suspended_flag(i_suspended_flag), .i_write_enable_latch(i_write_enable_latch),
    .i_terminate_enable(i_terminate_enable), .o_pe_abort(o_pe_abort), .o_page_undefined(o_page_undefined),
    .o_soft_reset(o_soft_reset), .o_cmd_busy(o_cmd_busy), .o_reset_armed(o_reset_armed));
  frtic_host u_frtic_host (.i_mclk(i_mclk), .i_io(io_w), .o_cs_n(cs_n), .o_sclk(sclk), .o_io(h_io),
    .o_io_oe(h_oe));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // n whole bytes of b, then stray bits that break the byte boundary
  task automatic frame(input logic [15:0] b, input int n, input int tail);
    logic [3:0] q;
    u_frtic_host.cs(1'b0);
    u_frtic_host.put(b[15:8], r);
    if (n > 1)
      u_frtic_host.put(b[7:0], r);
    repeat (tail) u_frtic_host.clk1(4'h1, 4'h1, q);
    u_frtic_host.cs(1'b1);
  endtask
  // busy span plus synchroniser latency
  task automatic settle();
    repeat (30) @(posedge i_mclk);
  endtask
  task automatic t_term();
    int a0;
    int s0;
    a0 = n_abort;
    s0 = n_srst;
    i_terminate_enable <= 1'b1;
    i_busy_flag <= 1'b1;
    i_write_enable_latch <= 1'b0;
    i_suspended_flag <= 1'b1;
    frame(16'hF0D0, 2, 0);
    chk("terminate busy", 1, o_cmd_busy);
    frame(16'h6600, 1, 0);
    settle();
    chk("abort", a0 + 1, n_abort);
    chk("page undefined", 1, o_page_undefined);
    chk("soft reset", s0, n_srst);
    chk("armed in busy", 0, o_reset_armed);
    frame(16'hF0D1, 2, 0);
    settle();
    frame(16'hF0D0, 2, 3);
    settle();
    i_terminate_enable <= 1'b0;
    frame(16'hF0D0, 2, 0);
    settle();
    chk("refused abort", a0 + 1, n_abort);
    $display("terminate test done");
  endtask
  task automatic t_reset();
    int s0;
    s0 = n_srst;
    i_busy_flag <= 1'b0;
    i_suspended_flag <= 1'b0;
    frame(16'h6600, 1, 4);
    settle();
    chk("armed partial", 0, o_reset_armed);
    frame(16'h9900, 1, 0);
    settle();
    chk("partial then reset", s0, n_srst);
    frame(16'h6600, 1, 0);
    settle();
    chk("armed", 1, o_reset_armed);
    frame(16'h0500, 1, 0);
    settle();
    chk("armed after other", 0, o_reset_armed);
    frame(16'h9900, 1, 0);
    settle();
    chk("lone reset", s0, n_srst);
    frame(16'h6600, 1, 0);
    frame(16'h9900, 1, 0);
    frame(16'h6600, 1, 0);
    settle();
    chk("soft reset", s0 + 1, n_srst);
    chk("armed in reset", 0, o_reset_armed);
    chk("page cleared", 0, o_page_undefined);
    $display("reset test done");
  endtask
  task automatic t_id1();
    u_frtic_host.cs(1'b0);
    u_frtic_host.put(8'h90, r);
    repeat (3) u_frtic_host.put(8'hFF, r);
    for (int i = 0; i < 4; i++)
    begin
      u_frtic_host.put(8'h00, r);
      chk("id1 byte", i[0] ? DEV : MFR, r);
    end
    u_frtic_host.cs(1'b1);
    chk("id1 release", 0, d_oe);
    $display("single id test done");
  endtask
  task automatic t_id4();
    logic [3:0] q;
    logic [7:0] b;
    u_frtic_host.cs(1'b0);
    u_frtic_host.put(8'h94, r);
    repeat (8) u_frtic_host.clk1(4'hA, 4'hF, q);
    repeat (4) u_frtic_host.clk1(4'h0, 4'h0, q);
    for (int i = 0; i < 8; i++)
    begin
      u_frtic_host.clk1(4'h0, 4'h0, q);
      b = {b[3:0], q};
      if (i[0])
        chk("id4 byte", i[1] ? DEV : MFR, b);
    end
    u_frtic_host.cs(1'b1);
    chk("id4 release", 0, d_oe);
    $display("quad id test done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (5) @(posedge i_mclk);
    t_term();
    t_reset();
    t_id1();
    t_id4();
    stop_test();
  end
  initial
  begin
    repeat (40000) @(posedge i_mclk);
    fail_count++;
    stop_test();
  end
endmodule
